// *** rtl/bts_params.svh ***
`ifndef BTS_PARAMS_SVH
`define BTS_PARAMS_SVH

// register offsets on the plain register port
`define BTS_ADDR_CONFIG_ONE 4'h0
`define BTS_ADDR_CONFIG_TWO 4'h2
`define BTS_ADDR_STATUS 4'h4

// bit_timing_config_one field positions
`define BTS_PRESCALE_LSB 0
`define BTS_PRESCALE_MSB 5
`define BTS_JUMP_LSB 6
`define BTS_JUMP_MSB 7

// bit_timing_config_two field positions
`define BTS_PROP_LSB 0
`define BTS_PROP_MSB 2
`define BTS_PHASE1_LSB 3
`define BTS_PHASE1_MSB 5
`define BTS_TRIPLE_BIT 6
`define BTS_PHASE2_FREE_BIT 7
`define BTS_PHASE2_LSB 8
`define BTS_PHASE2_MSB 10

// reset values
`define BTS_CONFIG_ONE_RST 8'h00
`define BTS_CONFIG_TWO_RST 11'h000

// timing counts
`define BTS_CLK_PERIOD_NS 100
`define BTS_PROC_TIME_TQ 4'h2
`define BTS_SYNC_SEG_TQ 4'h1

`endif

// *** rtl/bts_pkg.sv ***
package bts_pkg;

  // segments of one nominal bit time
  typedef enum logic [1:0] {
    BTS_SEG_SYNC,
    BTS_SEG_PROP,
    BTS_SEG_PHASE1,
    BTS_SEG_PHASE2
  } bts_seg_t;

  // state of the quantum generator
  typedef struct packed {
    logic [5:0] div;
    logic half;
    logic half_tick;
    logic tq_tick;
  } bts_tq_state_t;

  // state of the bit timing and sync logic
  typedef struct packed {
    logic [7:0] config_one;
    logic [10:0] config_two;
    logic [15:0] rdata;
    bts_seg_t seg;
    logic [3:0] cnt;
    logic [4:0] elapsed;
    logic [2:0] ext;
    logic [2:0] cut;
    logic rx_q;
    logic [2:0] samp;
    logic bit_val;
    logic bit_vld;
    logic hs_done;
    logic rs_done;
    logic hs_pulse;
    logic rs_pulse;
  } bts_state_t;

endpackage

// *** rtl/bts_quantum_gen.sv ***
`include "bts_params.svh"

module bts_quantum_gen
  import bts_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [5:0] prescale_i,
  input wire logic restart_i,
  output logic half_tick_o,
  output logic tq_tick_o
);

  bts_tq_state_t s_q; // registered state
  bts_tq_state_t s_d; // next state
  logic [7:0] gap_q; // cycles since last quantum, assertion helper only
  logic chg_q; // prescale moved since last quantum, assertion helper only

  //////////////////////////////////////////////////////////////////////////////
  // divide by prescale+1 to half quanta, then by two to full quanta
  always_comb
  begin
    s_d = s_q;
    s_d.half_tick = 1'b0;
    s_d.tq_tick = 1'b0;
    if (restart_i)
    begin
      // realign so the current cycle opens a fresh quantum
      s_d.div = 6'h00;
      s_d.half = 1'b0;
    end
    else if (s_q.div >= prescale_i)
    begin
      // >= so a lowered prescale never runs the counter off the top
      s_d.div = 6'h00;
      s_d.half_tick = 1'b1;
      s_d.tq_tick = s_q.half; // fixed divide-by-two stage
      s_d.half = ~s_q.half;
    end
    else
    begin
      s_d.div = s_q.div + 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign half_tick_o = s_q.half_tick;
  assign tq_tick_o = s_q.tq_tick;

  //////////////////////////////////////////////////////////////////////////////
  // helper counting the quantum period for the check below
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gap_q <= 8'h00;
      chg_q <= 1'b1;
    end
    else if (tq_tick_o || restart_i)
    begin
      gap_q <= 8'h01;
      chg_q <= restart_i;
    end
    else
    begin
      gap_q <= gap_q + 8'h01;
      chg_q <= chg_q | (prescale_i != s_q.div) & 1'b0 | ($past(prescale_i) != prescale_i);
    end
  end

  a_quantum_period: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tq_tick_o && !chg_q && !restart_i && $stable(prescale_i))
      |-> (gap_q == ({1'b0, 1'b0, prescale_i} + 8'h01) * 8'h02))
    else $error("quantum period differs from two times prescale plus one");

endmodule

// *** rtl/bts_bit_timing.sv ***
`include "bts_params.svh"

module bts_bit_timing
  import bts_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic rx_i,
  input wire logic bus_idle_i,
  output logic sample_bit_o,
  output logic sample_valid_o,
  output logic tq_tick_o,
  output logic hard_sync_o,
  output logic resync_o
);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  bts_state_t s_q; // registered state
  bts_state_t s_d; // next state
  logic half_tick; // half quantum strobe
  logic tq_tick; // full quantum strobe
  logic restart; // realign the quantum generator
  logic fall_edge; // recessive to dominant on rx
  logic triple; // three samples per bit
  logic [3:0] prop_len; // propagation length in quanta
  logic [3:0] ph1_base; // programmed first phase length
  logic [3:0] ph1_len; // first phase incl. lengthening
  logic [3:0] ph2_base; // programmed or derived second phase
  logic [3:0] ph2_len; // second phase after shortening
  logic [2:0] sjw_len; // jump width in quanta
  logic [3:0] ph2_rem; // quanta left in second phase
  logic [4:0] err; // positive phase error in quanta
  logic maj; // majority of the three samples

  //////////////////////////////////////////////////////////////////////////////
  // quantum generator
  bts_quantum_gen u_quantum (
    .ref_clk_i (ref_clk_i),
    .rst_i (rst_i),
    .prescale_i (s_q.config_one[`BTS_PRESCALE_MSB:`BTS_PRESCALE_LSB]),
    .restart_i (restart),
    .half_tick_o (half_tick),
    .tq_tick_o (tq_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // segment lengths decoded from the configuration
  always_comb
  begin
    triple = s_q.config_two[`BTS_TRIPLE_BIT];
    prop_len = {1'b0, s_q.config_two[`BTS_PROP_MSB:`BTS_PROP_LSB]} + 4'h1;
    ph1_base = {1'b0, s_q.config_two[`BTS_PHASE1_MSB:`BTS_PHASE1_LSB]} + 4'h1;
    ph1_len = ph1_base + {1'b0, s_q.ext};
    if (s_q.config_two[`BTS_PHASE2_FREE_BIT])
    begin
      ph2_base = {1'b0, s_q.config_two[`BTS_PHASE2_MSB:`BTS_PHASE2_LSB]} + 4'h1;
    end
    else
    begin
      // derived length never drops under the processing time
      ph2_base = (ph1_base > `BTS_PROC_TIME_TQ) ? ph1_base : `BTS_PROC_TIME_TQ;
    end
    // software keeps phase2 above the jump width, so no underflow here
    ph2_len = ph2_base - {1'b0, s_q.cut};
    sjw_len = {1'b0, s_q.config_one[`BTS_JUMP_MSB:`BTS_JUMP_LSB]} + 3'h1;
    ph2_rem = ph2_len - s_q.cnt;
    err = s_q.elapsed + 5'h01;
    maj = (s_q.samp[1] & s_q.samp[0]) | (s_q.samp[1] & rx_i) | (s_q.samp[0] & rx_i);
    fall_edge = s_q.rx_q & ~rx_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // quantum realign: hard sync, or an early edge that closes phase2 at once
  always_comb
  begin
    restart = 1'b0;
    if (fall_edge && bus_idle_i)
    begin
      restart = 1'b1;
    end
    else if (fall_edge && !s_q.hs_done && !s_q.rs_done && s_q.seg == BTS_SEG_PHASE2
             && ph2_rem <= {1'b0, sjw_len})
    begin
      restart = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: register port, segment sequencing, sampling, sync
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 16'h0000;
    s_d.bit_vld = 1'b0;
    s_d.hs_pulse = 1'b0;
    s_d.rs_pulse = 1'b0;
    s_d.rx_q = rx_i;

    // register writes
    if (wr_i && addr_i == `BTS_ADDR_CONFIG_ONE)
    begin
      s_d.config_one = wdata_i[7:0];
    end
    if (wr_i && addr_i == `BTS_ADDR_CONFIG_TWO)
    begin
      s_d.config_two = wdata_i[10:0];
    end

    // register reads, data only in the following cycle
    if (rd_i)
    begin
      case (addr_i)
        `BTS_ADDR_CONFIG_ONE: s_d.rdata = {8'h00, s_q.config_one};
        `BTS_ADDR_CONFIG_TWO: s_d.rdata = {5'h00, s_q.config_two};
        `BTS_ADDR_STATUS: s_d.rdata = {8'h00, s_q.cnt, s_q.seg, s_q.hs_done, s_q.bit_val};
        default: s_d.rdata = 16'h0000; // unmapped reads as zero
      endcase
    end

    // bus level collected every half quantum for the majority vote
    if (half_tick)
    begin
      s_d.samp = {s_q.samp[1:0], rx_i};
    end

    // segment sequencing on each quantum
    if (tq_tick)
    begin
      case (s_q.seg)
        BTS_SEG_SYNC:
        begin
          s_d.seg = BTS_SEG_PROP;
          s_d.cnt = 4'h0;
          s_d.elapsed = 5'h00;
        end
        BTS_SEG_PROP:
        begin
          s_d.elapsed = s_q.elapsed + 5'h01;
          if (s_q.cnt + 4'h1 >= prop_len)
          begin
            s_d.seg = BTS_SEG_PHASE1;
            s_d.cnt = 4'h0;
          end
          else
          begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
        end
        BTS_SEG_PHASE1:
        begin
          s_d.elapsed = s_q.elapsed + 5'h01;
          if (s_q.cnt + 4'h1 >= ph1_len)
          begin
            // sample point: end of the first phase
            s_d.seg = BTS_SEG_PHASE2;
            s_d.cnt = 4'h0;
            s_d.ext = 3'h0;
            s_d.bit_val = triple ? maj : rx_i;
            s_d.bit_vld = 1'b1;
          end
          else
          begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
        end
        BTS_SEG_PHASE2:
        begin
          if (s_q.cnt + 4'h1 >= ph2_len)
          begin
            // a new bit opens; sync bookkeeping starts over
            s_d.seg = BTS_SEG_SYNC;
            s_d.cnt = 4'h0;
            s_d.cut = 3'h0;
            s_d.hs_done = 1'b0;
            s_d.rs_done = 1'b0;
          end
          else
          begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
        end
        default:
        begin
          s_d.seg = BTS_SEG_SYNC;
          s_d.cnt = 4'h0;
        end
      endcase
    end

    // edge handling wins over the quantum sequencing above
    if (fall_edge && bus_idle_i)
    begin
      // start of frame: the edge itself lies in the new sync segment
      s_d.seg = BTS_SEG_SYNC;
      s_d.cnt = 4'h0;
      s_d.elapsed = 5'h00;
      s_d.ext = 3'h0;
      s_d.cut = 3'h0;
      s_d.hs_done = 1'b1;
      s_d.rs_done = 1'b0;
      s_d.hs_pulse = 1'b1;
    end
    else if (fall_edge && !s_q.hs_done && !s_q.rs_done)
    begin
      case (s_q.seg)
        BTS_SEG_PROP, BTS_SEG_PHASE1:
        begin
          // late edge: lengthen phase1 by the error, at most the jump width
          s_d.ext = (err >= {2'b00, sjw_len}) ? sjw_len : err[2:0];
          s_d.rs_done = 1'b1;
          s_d.rs_pulse = 1'b1;
        end
        BTS_SEG_PHASE2:
        begin
          s_d.rs_pulse = 1'b1;
          if (ph2_rem <= {1'b0, sjw_len})
          begin
            // error within reach: this edge becomes the next sync segment
            s_d.seg = BTS_SEG_SYNC;
            s_d.cnt = 4'h0;
            s_d.cut = 3'h0;
            s_d.rs_done = 1'b0;
          end
          else
          begin
            s_d.cut = sjw_len;
            s_d.rs_done = 1'b1;
          end
        end
        default:
        begin
          // edge inside sync segment: no phase error
          s_d.rs_done = s_q.rs_done;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; idle rx level is recessive, so rx_q resets high
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.config_one <= `BTS_CONFIG_ONE_RST;
      s_q.config_two <= `BTS_CONFIG_TWO_RST;
      s_q.rx_q <= 1'b1;
      s_q.samp <= 3'h7;
      s_q.bit_val <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_o = s_q.rdata;
  assign sample_bit_o = s_q.bit_val;
  assign sample_valid_o = s_q.bit_vld;
  assign tq_tick_o = tq_tick;
  assign hard_sync_o = s_q.hs_pulse;
  assign resync_o = s_q.rs_pulse;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_prop_length: assert property (
    (tq_tick && s_q.seg == BTS_SEG_PROP && s_q.cnt + 4'h1 < prop_len && !fall_edge)
      |=> s_q.seg == BTS_SEG_PROP)
    else $error("propagation segment ended early");

  a_phase1_exit: assert property (
    (s_q.seg == BTS_SEG_PHASE1 && $past(s_q.seg) == BTS_SEG_PROP)
      |-> $past(s_q.cnt) + 4'h1 == $past(prop_len))
    else $error("phase1 entered at wrong propagation count");

  a_phase2_derived: assert property (
    !s_q.config_two[`BTS_PHASE2_FREE_BIT] |-> (ph2_base >= 4'h2 && ph2_base >= ph1_base))
    else $error("derived phase2 below phase1 or processing time");

  a_sample_point: assert property (
    sample_valid_o |-> ($past(s_q.seg) == BTS_SEG_PHASE1 && s_q.seg == BTS_SEG_PHASE2))
    else $error("bit sampled outside end of phase1");

  a_majority_vote: assert property (
    (tq_tick && s_q.seg == BTS_SEG_PHASE1 && s_q.cnt + 4'h1 >= ph1_len && !fall_edge)
      |=> sample_bit_o == ($past(triple) ? $past(maj) : $past(rx_i)))
    else $error("sampled bit differs from selected vote");

  a_hard_restart: assert property (
    (fall_edge && bus_idle_i)
      |=> (s_q.seg == BTS_SEG_SYNC && s_q.cnt == 4'h0 && hard_sync_o) ##1 !hard_sync_o)
    else $error("hard sync did not restart at sync segment");

  a_no_resync_hard: assert property (
    s_q.hs_done |=> !resync_o)
    else $error("resync inside a hard synced bit");

  a_jump_bound: assert property (
    resync_o |-> (s_q.ext <= sjw_len && s_q.cut <= sjw_len))
    else $error("phase adjustment beyond jump width");

  a_bit_order: assert property (
    (tq_tick && s_q.seg == BTS_SEG_SYNC && !fall_edge) |=> s_q.seg == BTS_SEG_PROP)
    else $error("sync segment not followed by propagation");

endmodule

// *** bench/bts_remote_node.sv ***
////////////////////////////////////////////////////////////////////////////////
// far-side node: drives the received bus level and the idle report
module bts_remote_node (
  input wire logic ref_clk_i,
  output logic rx_o,
  output logic bus_idle_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // an undriven bus rests recessive, so start high and idle
  initial
  begin
    rx_o = 1'b1;
    bus_idle_o = 1'b1;
  end

  // both lines change together just after an edge so no race with the dut
  task automatic drive(input logic lvl, input logic idl);
    @(posedge ref_clk_i);
    rx_o <= lvl;
    bus_idle_o <= idl;
  endtask
endmodule

// *** bench/can_bit_timing_sync_tb.sv ***
module can_bit_timing_sync_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk_i;
  logic rst_i;
  logic wr_i;
  logic rd_i;
  logic [3:0] addr_i;
  logic [15:0] wdata_i;
  logic [15:0] rdata_o;
  logic rx_i;
  logic bus_idle_i;
  logic sample_bit_o;
  logic sample_valid_o;
  logic tq_tick_o;
  logic hard_sync_o;
  logic resync_o;
  int fail_count;
  int n_tests;
  int cyc;
  int hs_cnt;
  int rs_cnt;
  int regs [16]; // register model, unmapped places stay zero

  bts_bit_timing dut (
    .ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_i,
    .bus_idle_i, .sample_bit_o, .sample_valid_o, .tq_tick_o, .hard_sync_o, .resync_o
  );

  bts_remote_node node (
    .ref_clk_i,
    .rx_o(rx_i),
    .bus_idle_o(bus_idle_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, cycle stamp and counts of the sync pulses
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (hard_sync_o === 1'b1)
      hs_cnt <= hs_cnt + 1;
    if (resync_o === 1'b1)
      rs_cnt <= rs_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare, bus cycles and event waits
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    // only the two config places hold bits; status and holes ignore writes
    if (a == 4'h0)
      regs[a] = int'(d & 16'h00ff);
    else if (a == 4'h2)
      regs[a] = int'(d & 16'h07ff);
  endtask

  task automatic rd_chk(input logic [3:0] a);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    check("rdata", rdata_o, 16'(regs[a]));
  endtask

  // bounded wait: 0 quantum tick, 1 sample, 2 hard sync; returns its stamp
  task automatic wait_ev(input int which, output int at);
    int n;
    logic [2:0] ev;
    n = 0;
    ev = 3'h0;
    while (ev[which] !== 1'b1 && n < 3000)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
      ev = {hard_sync_o, sample_valid_o, tq_tick_o};
    end
    if (n >= 3000)
      check("event wait", 16'h0, 16'h1);
    at = cyc;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic tq_case(input int p);
    int a;
    int b;
    wr(4'h0, 16'(p));
    wait_ev(0, a);
    wait_ev(0, a);
    wait_ev(0, b);
    check("tq period", 16'(b - a), 16'(2 * (p + 1)));
  endtask

  // prop 4, phase1 5, phase2 6 or max(phase1, 2); sample near 62 percent (phase2 6) or 67 percent (phase2 5)
  // phase2 stays above every jump width and below prop+phase1
  task automatic sync_case(input int k);
    int t;
    int ph2;
    int nq;
    int h;
    int s0;
    int s1;
    int s2;
    int hs;
    int rs;
    t = 2 * (k + 1);
    ph2 = k[0] ? 6 : 5;
    nq = 1 + 4 + 5 + ph2;
    wr(4'h0, 16'((k << 6) | k));
    wr(4'h2, k[0] ? 16'h05a3 : 16'h0523);
    wait_ev(0, h);
    node.drive(1'b0, 1'b1);
    wait_ev(2, h);
    node.drive(1'b0, 1'b0);
    wait_ev(1, s0);
    // sync, prop and phase1 quanta, plus the registered sample strobe cycle
    check("hard sync to sample", 16'(s0 - h), 16'(t * 10 + 1));
    check("first bit", {15'h0, sample_bit_o}, 16'h0);
    node.drive(1'b1, 1'b0);
    wait_ev(1, s1);
    check("bit time", 16'(s1 - s0), 16'(t * nq));
    check("second bit", {15'h0, sample_bit_o}, 16'h1);
    hs = hs_cnt;
    rs = rs_cnt;
    // late edge two quanta into phase1, well beyond any jump width
    wait (cyc == s1 + t * (ph2 + 7) - 1);
    node.drive(1'b0, 1'b0);
    wait_ev(1, s2);
    check("resync bit time", 16'(s2 - s1), 16'(t * (nq + k + 1)));
    check("resync pulse", 16'(rs_cnt - rs), 16'h1);
    check("busy edge hard sync", 16'(hs_cnt - hs), 16'h0);
    node.drive(1'b1, 1'b1);
    repeat (3 * t * nq) @(posedge ref_clk_i);
  endtask

  // sixteen-cycle quantum so the three votes lie eight cycles apart
  task automatic triple_case(input logic three, input int g, input logic exp);
    int h;
    int s;
    int rs;
    wr(4'h0, 16'h0007);
    wr(4'h2, three ? 16'h0050 : 16'h0010);
    node.drive(1'b0, 1'b1);
    wait_ev(2, h);
    node.drive(1'b0, 1'b0);
    // five quanta to the sampling quantum, strobe shows one cycle later
    s = h + 81;
    wait (cyc == s - g - 1);
    node.drive(1'b1, 1'b0);
    wait (cyc == s - 1);
    node.drive(1'b0, 1'b0);
    rs = rs_cnt;
    #1;
    check("sample valid", {15'h0, sample_valid_o}, 16'h1);
    check("sampled level", {15'h0, sample_bit_o}, {15'h0, exp});
    wait_ev(1, s);
    check("resync in hard bit", 16'(rs_cnt - rs), 16'h0);
    node.drive(1'b1, 1'b1);
    repeat (300) @(posedge ref_clk_i);
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under a quarter of this span
  initial
  begin
    #3000000;
    fail_count++;
    print_verdict();
  end

  initial
  begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    void'($urandom(32'hcdbd1ee9));
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_chk(4'h0);
    rd_chk(4'h2);
    wr(4'h6, 16'hffff);
    rd_chk(4'h6);
    for (int i = 0; i < 8; i++)
    begin
      wr(i[0] ? 4'h2 : 4'h0, 16'($urandom));
      rd_chk(4'h0);
      rd_chk(4'h2);
    end
    tq_case(0);
    tq_case(63);
    tq_case($urandom_range(62, 1));
    for (int k = 0; k < 4; k++)
      sync_case(k);
    triple_case(1'b0, 4, 1'b1);
    triple_case(1'b1, 4, 1'b0);
    triple_case(1'b1, 12, 1'b1);
    print_verdict();
  end
endmodule
